// ---- design/arb_pkg.sv ----
// Constants, timer indices, register map and carrier types of the protection arbiter.
// Assumes a 10 MHz core clock and a 32-bit Avalon-MM register bus.
package arb_pkg;

    // ==========================================================
    // Clock period (nanoseconds) and delay times (microseconds, rounded up to cycles)
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned OVCHG_DET_US  = 1000000;
    localparam int unsigned OVCHG_RET_US  = 16000;
    localparam int unsigned OVDIS_DET_US  = 20000;
    localparam int unsigned OVDIS_RET_US  = 1000;
    localparam int unsigned OVCUR_DET_US  = 10000;
    localparam int unsigned CUR_RET_US    = 1000;
    localparam int unsigned SHORT_DET_US  = 250;
    localparam int unsigned CHGR_DET_US   = 8000;
    localparam int unsigned CHGR_RET_US   = 1000;

    localparam int unsigned TIMER_W = 24;
    localparam logic [23:0] OVCHG_DET_CYC =
        24'((OVCHG_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] OVCHG_RET_CYC =
        24'((OVCHG_RET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] OVDIS_DET_CYC =
        24'((OVDIS_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] OVDIS_RET_CYC =
        24'((OVDIS_RET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] OVCUR_DET_CYC =
        24'((OVCUR_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] CUR_RET_CYC =
        24'((CUR_RET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] SHORT_DET_CYC =
        24'((SHORT_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] CHGR_DET_CYC =
        24'((CHGR_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [23:0] CHGR_RET_CYC =
        24'((CHGR_RET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Shortening mode divides counted delays by two to this power
    localparam int unsigned SHORT_SHIFT = 4;

    // ==========================================================
    // Timer indices
    localparam int unsigned TI_OVCHG_DET = 0;
    localparam int unsigned TI_OVCHG_RET = 1;
    localparam int unsigned TI_OVDIS_DET = 2;
    localparam int unsigned TI_OVDIS_RET = 3;
    localparam int unsigned TI_OVCUR_DET = 4;
    localparam int unsigned TI_CUR_RET   = 5;
    localparam int unsigned TI_SHORT_DET = 6;
    localparam int unsigned TI_CHGR_DET  = 7;
    localparam int unsigned TI_CHGR_RET  = 8;
    localparam int unsigned NUM_TIMERS   = 9;

    // ==========================================================
    // Register map (byte offsets) and fields
    localparam logic [3:0] REG_STATUS    = 4'h0;
    localparam logic [3:0] REG_CLEAR     = 4'h4;
    localparam logic [3:0] REG_ENABLE    = 4'h8;
    localparam logic [3:0] REG_STATE     = 4'hC;
    localparam int unsigned EV_W         = 6;
    localparam int unsigned EV_STANDBY   = 5;
    localparam logic [5:0] STATUS_RESET  = 6'h00;
    localparam logic [5:0] ENABLE_RESET  = 6'h00;
    localparam int unsigned SYNC_W       = 7;

    // ==========================================================
    // Types
    typedef struct packed {
        logic charger;
        logic short_c;
        logic ovcur;
        logic ovdis;
        logic ovchg;
    } det_flags_type;

    localparam det_flags_type DET_RESET = '0;

    typedef enum logic [1:0] {
        TERM_OPEN = 2'h0,
        TERM_UP   = 2'h1,
        TERM_DOWN = 2'h2
    } term_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_type;

endpackage

// ---- design/delay_timer.sv ----
// Delay counter: counts while armed, clears when disarmed.
// Assumes the limit is stable while armed.
module delay_timer #(
    parameter int unsigned WIDTH = 24
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Control
    input  wire logic             i_arm,
    input  wire logic [WIDTH-1:0] i_limit,
    output logic                  o_done
);

    logic [WIDTH-1:0] count_r;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count_r <= '0;
        else if (!i_arm)
            count_r <= '0;
        else if (count_r < i_limit)
            count_r <= count_r + 1'b1;
    end

    assign o_done = i_arm && (count_r >= i_limit);

endmodule // delay_timer

// ---- design/pin_sync3.sv ----
// Three-stage synchroniser for comparator and strap inputs.
// Assumes asynchronous inputs; output changes once stages two and three agree.
module pin_sync3 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_r <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
        end
        else
        begin
            meta_r <= i_async;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // Agreement filter keeps single-cycle glitches out
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_level <= '0;
        else
            o_level <= (s2_r & s3_r) | (o_level & (s2_r | s3_r));
    end

endmodule // pin_sync3

// ---- design/protection_fault_priority_arbiter.sv ----
// Detection priority arbiter of a two-cell protection controller.
// Assumes comparator flags arrive unsynchronised; registers on Avalon-MM.
// Notes on behaviour
// R1: Over-charge outranks over-discharge; discharge restarts later
// R2: Over-charge first leaves sense node open
// R3: Discharge after over-charge: no standby, pull-up
// R4: Over-charge counting unaffected by over-current
// R5: Over-charge first aborts pending over-current
// R6: Over-current first selects pull-down return path
// R7: New over-charge interrupts over-discharge counting
// R8: Over-discharge proceeds though over-current came first
// R9: Over-discharge first aborts pending over-current
// R10: Over-discharge detected: pull-up and enter standby
// R11: Short-circuit detection runs fully independent
// R12: Over-charger waits until discharge faults return
// R13: Confirmed over-charge drives charge gate low
// R14: Shorten select cuts every counted delay but the short-circuit delay
// R15: Decisions update outputs in one cycle
// R16: Interrupted detection restarts its full delay
module protection_fault_priority_arbiter #(
    parameter logic [23:0] P_OVCHG_DET = arb_pkg::OVCHG_DET_CYC,
    parameter logic [23:0] P_OVCHG_RET = arb_pkg::OVCHG_RET_CYC,
    parameter logic [23:0] P_OVDIS_DET = arb_pkg::OVDIS_DET_CYC,
    parameter logic [23:0] P_OVDIS_RET = arb_pkg::OVDIS_RET_CYC,
    parameter logic [23:0] P_OVCUR_DET = arb_pkg::OVCUR_DET_CYC,
    parameter logic [23:0] P_CUR_RET   = arb_pkg::CUR_RET_CYC,
    parameter logic [23:0] P_CHGR_DET  = arb_pkg::CHGR_DET_CYC,
    parameter logic [23:0] P_CHGR_RET  = arb_pkg::CHGR_RET_CYC
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Comparator flags and straps
    input  wire logic        i_ovchg_cmp,
    input  wire logic        i_ovdis_cmp,
    input  wire logic        i_ovcur_cmp,
    input  wire logic        i_short_cmp,
    input  wire logic        i_charger_cmp,
    input  wire logic        i_sbret_cmp,
    input  wire logic        i_shorten_sel,
    // Gate and sense node control
    output logic             o_charge_gate,
    output logic             o_discharge_gate,
    output logic             o_pull_up_sel,
    output logic             o_pull_down_sel,
    output logic             o_standby,
    // Avalon-MM slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // Interrupt
    output logic             o_irq
);

    // ==========================================================
    // Input synchronisation
    logic [arb_pkg::SYNC_W-1:0] sync_lvl;
    arb_pkg::det_flags_type     cond;
    logic                       sbret;
    logic                       shorten;

    pin_sync3 #(
        .WIDTH (arb_pkg::SYNC_W)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_shorten_sel, i_sbret_cmp, i_charger_cmp, i_short_cmp,
                   i_ovcur_cmp, i_ovdis_cmp, i_ovchg_cmp}),
        .o_level (sync_lvl)
    );

    assign cond    = arb_pkg::det_flags_type'(sync_lvl[4:0]);
    assign sbret   = sync_lvl[5];
    assign shorten = sync_lvl[6];

    // ==========================================================
    // Delay timers
    logic [arb_pkg::NUM_TIMERS-1:0] arm;
    logic [arb_pkg::NUM_TIMERS-1:0] done;
    logic [23:0]                    limit [arb_pkg::NUM_TIMERS];

    function automatic logic [23:0] shrink(input logic [23:0] v, input logic s);
        shrink = s ? (v >> arb_pkg::SHORT_SHIFT) : v; // [R14]
    endfunction

    always_comb
    begin
        limit[arb_pkg::TI_OVCHG_DET] = shrink(P_OVCHG_DET, shorten);
        limit[arb_pkg::TI_OVCHG_RET] = shrink(P_OVCHG_RET, shorten);
        limit[arb_pkg::TI_OVDIS_DET] = shrink(P_OVDIS_DET, shorten);
        limit[arb_pkg::TI_OVDIS_RET] = shrink(P_OVDIS_RET, shorten);
        limit[arb_pkg::TI_OVCUR_DET] = shrink(P_OVCUR_DET, shorten);
        limit[arb_pkg::TI_CUR_RET]   = shrink(P_CUR_RET, shorten);
        // Short-circuit delay is not counter-set, so shortening skips it
        limit[arb_pkg::TI_SHORT_DET] = arb_pkg::SHORT_DET_CYC; // [R14]
        limit[arb_pkg::TI_CHGR_DET]  = shrink(P_CHGR_DET, shorten);
        limit[arb_pkg::TI_CHGR_RET]  = shrink(P_CHGR_RET, shorten);
    end

    // Disarming clears a timer, so a resumed detection counts in full
    for (genvar g = 0; g < arb_pkg::NUM_TIMERS; g++)
    begin : g_timer
        delay_timer #(
            .WIDTH (arb_pkg::TIMER_W)
        ) u_timer (
            .i_clock (i_clock),
            .i_rst_n (i_rst_n),
            .i_arm   (arm[g]), // [R16]
            .i_limit (limit[g]),
            .o_done  (done[g])
        );
    end

    // ==========================================================
    // Arbitration
    arb_pkg::det_flags_type det_r;
    arb_pkg::det_flags_type det_nxt;
    logic                   standby_r;
    logic                   standby_nxt;
    logic                   chg_first_r;
    logic                   chg_first_nxt;
    logic                   cur_lead_r;
    logic                   cur_lead_nxt;
    arb_pkg::term_type      term_nxt;
    logic                   ovchg_pend;
    logic                   ovchg_busy;
    logic                   ovdis_busy;
    logic                   dis_fault;

    assign ovchg_pend = cond.ovchg && !det_r.ovchg;
    assign ovchg_busy = cond.ovchg || det_r.ovchg;
    assign ovdis_busy = cond.ovdis || det_r.ovdis;
    assign dis_fault  = det_r.ovdis || det_r.ovcur || det_r.short_c;

    always_comb
    begin
        arm = '0;
        arm[arb_pkg::TI_OVCHG_DET] = cond.ovchg && !det_r.ovchg; // [R4]
        arm[arb_pkg::TI_OVCHG_RET] = det_r.ovchg && !cond.ovchg;
        // Pending over-charge holds off and resets discharge counting
        arm[arb_pkg::TI_OVDIS_DET] = cond.ovdis && !det_r.ovdis
                                     && !ovchg_pend; // [R1] [R7] [R8]
        arm[arb_pkg::TI_OVDIS_RET] = det_r.ovdis && !standby_r && !cond.ovdis;
        arm[arb_pkg::TI_OVCUR_DET] = cond.ovcur && !det_r.ovcur && !det_r.ovdis
                                     && (cur_lead_r
                                         || (!ovchg_busy && !ovdis_busy)); // [R5] [R9]
        arm[arb_pkg::TI_CUR_RET]   = (det_r.ovcur || det_r.short_c)
                                     && !cond.ovcur && !cond.short_c;
        arm[arb_pkg::TI_SHORT_DET] = cond.short_c && !det_r.short_c; // [R11]
        arm[arb_pkg::TI_CHGR_DET]  = cond.charger && !det_r.charger
                                     && !dis_fault; // [R12]
        arm[arb_pkg::TI_CHGR_RET]  = det_r.charger && !cond.charger;
    end

    // Over-current leads only if it began before both cell faults
    assign cur_lead_nxt = cond.ovcur
                          && (cur_lead_r || (!ovchg_busy && !ovdis_busy)); // [R5] [R9]

    always_comb
    begin
        det_nxt = det_r;
        if (done[arb_pkg::TI_OVCHG_DET])
            det_nxt.ovchg = 1'b1;
        else if (done[arb_pkg::TI_OVCHG_RET])
            det_nxt.ovchg = 1'b0;
        if (done[arb_pkg::TI_OVDIS_DET])
            det_nxt.ovdis = 1'b1;
        else if (done[arb_pkg::TI_OVDIS_RET])
            det_nxt.ovdis = 1'b0;
        if (done[arb_pkg::TI_OVCUR_DET])
            det_nxt.ovcur = 1'b1;
        else if (done[arb_pkg::TI_CUR_RET])
            det_nxt.ovcur = 1'b0;
        if (done[arb_pkg::TI_SHORT_DET])
            det_nxt.short_c = 1'b1; // [R11]
        else if (done[arb_pkg::TI_CUR_RET])
            det_nxt.short_c = 1'b0;
        if (done[arb_pkg::TI_CHGR_DET])
            det_nxt.charger = 1'b1;
        else if (done[arb_pkg::TI_CHGR_RET])
            det_nxt.charger = 1'b0;
    end

    always_comb
    begin
        standby_nxt = standby_r;
        if (done[arb_pkg::TI_OVDIS_DET] && !det_r.ovchg)
            standby_nxt = 1'b1; // [R10] [R3]
        else if (sbret || !det_r.ovdis)
            standby_nxt = 1'b0;
    end

    always_comb
    begin
        chg_first_nxt = chg_first_r;
        if (done[arb_pkg::TI_OVCHG_DET])
            chg_first_nxt = !(det_r.ovcur || det_r.short_c);
        else if (!det_r.ovchg)
            chg_first_nxt = 1'b0;
    end

    always_comb
    begin
        if (det_nxt.ovdis)
            term_nxt = arb_pkg::TERM_UP; // [R10] [R3]
        else if ((det_nxt.ovcur || det_nxt.short_c)
                 && !(det_nxt.ovchg && chg_first_nxt))
            term_nxt = arb_pkg::TERM_DOWN; // [R6]
        else
            term_nxt = arb_pkg::TERM_OPEN; // [R2]
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            det_r       <= arb_pkg::DET_RESET;
            standby_r   <= 1'b0;
            chg_first_r <= 1'b0;
            cur_lead_r  <= 1'b0;
        end
        else
        begin
            det_r       <= det_nxt;
            standby_r   <= standby_nxt;
            chg_first_r <= chg_first_nxt;
            cur_lead_r  <= cur_lead_nxt;
        end
    end

    // Outputs load from the next state, so they move with the decision
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_charge_gate    <= 1'b1;
            o_discharge_gate <= 1'b1;
            o_pull_up_sel    <= 1'b0;
            o_pull_down_sel  <= 1'b0;
            o_standby        <= 1'b0;
        end
        else
        begin
            o_charge_gate    <= !(det_nxt.ovchg || det_nxt.charger); // [R13] [R15]
            o_discharge_gate <= !(det_nxt.ovdis || det_nxt.ovcur
                                  || det_nxt.short_c); // [R15]
            o_pull_up_sel    <= (term_nxt == arb_pkg::TERM_UP); // [R15]
            o_pull_down_sel  <= (term_nxt == arb_pkg::TERM_DOWN);
            o_standby        <= standby_nxt;
        end
    end

    // ==========================================================
    // Bus slave
    arb_pkg::bus_state_type bus_state_r;
    logic [31:0]            rd_mux;
    logic                   wr_take;
    logic [arb_pkg::EV_W-1:0] status_r;
    logic [arb_pkg::EV_W-1:0] status_nxt;
    logic [arb_pkg::EV_W-1:0] enable_r;
    logic [arb_pkg::EV_W-1:0] enable_nxt;
    logic [arb_pkg::EV_W-1:0] clr_mask;
    logic [arb_pkg::EV_W-1:0] events;

    // Write lands at the edge where the master sees waitrequest low
    assign wr_take = (bus_state_r == arb_pkg::BUS_ACK) && i_write && i_byteenable[0];

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bus_state_r   <= arb_pkg::BUS_IDLE;
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h0000_0000;
        end
        else
        begin
            case (bus_state_r)
                arb_pkg::BUS_IDLE:
                begin
                    if (i_read || i_write)
                    begin
                        bus_state_r   <= arb_pkg::BUS_ACK;
                        o_waitrequest <= 1'b0;
                        o_readdata    <= i_read ? rd_mux : 32'h0000_0000;
                    end
                end
                arb_pkg::BUS_ACK:
                begin
                    bus_state_r   <= arb_pkg::BUS_IDLE;
                    o_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state_r   <= arb_pkg::BUS_IDLE;
                    o_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        case ({i_address[3:2], 2'b00})
            arb_pkg::REG_STATUS: rd_mux = 32'(status_r);
            arb_pkg::REG_ENABLE: rd_mux = 32'(enable_r);
            arb_pkg::REG_STATE:  rd_mux = 32'({shorten, sbret, term_nxt, standby_r, det_r});
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Interrupts
    assign events = {standby_nxt && !standby_r, det_nxt & ~det_r};
    assign clr_mask = (wr_take && i_address[3:2] == arb_pkg::REG_CLEAR[3:2])
                      ? i_writedata[arb_pkg::EV_W-1:0] : '0;
    // A new event in the clearing cycle survives
    assign status_nxt = (status_r & ~clr_mask) | events;
    assign enable_nxt = (wr_take && i_address[3:2] == arb_pkg::REG_ENABLE[3:2])
                        ? i_writedata[arb_pkg::EV_W-1:0] : enable_r;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_r <= arb_pkg::STATUS_RESET;
            enable_r <= arb_pkg::ENABLE_RESET;
            o_irq    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
            o_irq    <= |(status_nxt & enable_nxt);
        end
    end

endmodule // protection_fault_priority_arbiter

// ---- sim/arb_monitor.sv ----
// Port-level checker of the protection arbiter.
// Assumes it is bound to the arbiter top module.
module arb_monitor (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // Observed ports
    input  wire logic i_ovchg_cmp,
    input  wire logic i_ovdis_cmp,
    input  wire logic i_ovcur_cmp,
    input  wire logic i_short_cmp,
    input  wire logic i_charger_cmp,
    input  wire logic i_shorten_sel,
    input  wire logic i_read,
    input  wire logic i_write,
    input  wire logic o_charge_gate,
    input  wire logic o_discharge_gate,
    input  wire logic o_pull_up_sel,
    input  wire logic o_pull_down_sel,
    input  wire logic o_standby,
    input  wire logic o_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sync plus shortened count, with margin
    localparam int FAST_MAX = 20;
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    chk_pull_excl: assert property
        (!(o_pull_up_sel && o_pull_down_sel)) else $error("both pull paths on");
    chk_standby_up: assert property
        (o_standby |-> o_pull_up_sel && !o_discharge_gate) else $error("standby without pull-up");
    chk_down_gate: assert property
        (o_pull_down_sel |-> !o_discharge_gate) else $error("pull-down with gate on");
    chk_ack_next: assert property
        ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("no ack");
    chk_ack_pulse: assert property
        (!o_waitrequest |=> o_waitrequest) else $error("ack longer than one cycle");
    chk_chg_cause: assert property
        ($fell(o_charge_gate) |-> i_ovchg_cmp || i_charger_cmp) else $error("charge off uncaused");
    chk_dis_cause: assert property
        ($fell(o_discharge_gate) |-> i_ovdis_cmp || i_ovcur_cmp || i_short_cmp)
        else $error("discharge off uncaused");
    chk_fast_delay: assert property
        ($rose(i_ovchg_cmp) && i_shorten_sel && o_charge_gate |-> ##[1:FAST_MAX] !o_charge_gate)
        else $error("shortened delay too long");
    chk_slow_delay: assert property
        ($rose(i_ovchg_cmp) && !i_shorten_sel && o_charge_gate |-> o_charge_gate [*8])
        else $error("normal delay too short");
endmodule // arb_monitor

bind protection_fault_priority_arbiter arb_monitor u_mon (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ovchg_cmp(i_ovchg_cmp),
    .i_ovdis_cmp(i_ovdis_cmp), .i_ovcur_cmp(i_ovcur_cmp), .i_short_cmp(i_short_cmp),
    .i_charger_cmp(i_charger_cmp), .i_shorten_sel(i_shorten_sel), .i_read(i_read),
    .i_write(i_write), .o_charge_gate(o_charge_gate), .o_discharge_gate(o_discharge_gate),
    .o_pull_up_sel(o_pull_up_sel), .o_pull_down_sel(o_pull_down_sel),
    .o_standby(o_standby), .o_waitrequest(o_waitrequest));

// ---- sim/fet_model.sv ----
// Model of the external transistors and charger at the negative node.
// Assumes the bench says when a charger is plugged in.
module fet_model (
    // Gate and charger
    input  wire logic i_discharge_gate,
    input  wire logic i_plug,
    // Return comparator
    output logic      o_sbret
);
    timeunit 1ns;
    timeprecision 1ns;
    // Charger drags the node low only through the body diode of an off transistor
    assign o_sbret = i_plug & ~i_discharge_gate;
endmodule // fet_model

// ---- sim/testbench.sv ----
// Self-checking bench of the protection arbiter.
// Assumes 32-cycle delay parameters and a 10 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] N = 24'h000020;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [4:0]  cond    = 5'h00;
    logic        sh      = 1'b0;
    logic        plug    = 1'b0;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [3:0]  adr     = 4'h0;
    logic [31:0] wd      = 32'h0;
    logic [31:0] rdata, rdat;
    logic        cg, dg, up, dn, sb, irq, wt, sbret;
    logic [15:0] lf      = 16'h2EB2;
    int          bad_count = 0;
    int          cmp_count = 0;
    // ==========================================================
    // Design and far side
    protection_fault_priority_arbiter #(.P_OVCHG_DET(N), .P_OVCHG_RET(N), .P_OVDIS_DET(N),
        .P_OVDIS_RET(N), .P_OVCUR_DET(N), .P_CUR_RET(N), .P_CHGR_DET(N), .P_CHGR_RET(N)) DUT (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ovchg_cmp(cond[0]), .i_ovdis_cmp(cond[1]),
        .i_ovcur_cmp(cond[2]), .i_short_cmp(cond[3]), .i_charger_cmp(cond[4]),
        .i_sbret_cmp(sbret), .i_shorten_sel(sh), .o_charge_gate(cg), .o_discharge_gate(dg),
        .o_pull_up_sel(up), .o_pull_down_sel(dn), .o_standby(sb), .i_address(adr),
        .i_read(rd), .i_write(wr), .i_writedata(wd), .i_byteenable(4'hF),
        .o_readdata(rdata), .o_waitrequest(wt), .o_irq(irq));
    fet_model u_fet (.i_discharge_gate(dg), .i_plug(plug), .o_sbret(sbret));
    always #50 i_clock = ~i_clock;
    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            $display("BAD %s exp %h seen %h", n, e, s);
            bad_count++;
        end
    endtask
    // Packed as charge, discharge, pull-up, pull-down, standby
    task automatic outs(input logic [4:0] e);
        check("gates", {27'h0, cg, dg, up, dn, sb}, {27'h0, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic drive(input logic [4:0] v);
        @(posedge i_clock);
        cond <= v;
    endtask
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge i_clock);
        while (wt !== 1'b0) @(posedge i_clock);
        rdat = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Drops all conditions, checks the sticky events, clears them
    task automatic settle(input string name, input logic [31:0] e);
        drive(5'h00);
        // Charger lifts standby, else an over-discharge held in standby never returns
        plug <= 1'b1;
        cyc(150);
        plug <= 1'b0;
        outs(5'h18);
        bus(1'b0, 4'h0, 32'h0);
        check("status", rdat, e);
        bus(1'b1, 4'h4, 32'h3F);
        cyc(1);
        check("irq", irq, 32'h0);
        $display("test %s done", name);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        cyc(6);
        i_rst_n <= 1'b1;
        cyc(2);
        outs(5'h18);
        bus(1'b0, 4'h8, 32'h0);
        check("enable rst", rdat, {26'h0, arb_pkg::ENABLE_RESET});
        lf = lfsr(lf);
        bus(1'b1, 4'h8, {16'h0, lf});
        bus(1'b0, 4'h8, 32'h0);
        check("enable", rdat, {26'h0, lf[5:0]});
        bus(1'b1, 4'h0, {16'h0, lf});
        bus(1'b0, 4'h0, 32'h0);
        check("status ro", rdat, {26'h0, arb_pkg::STATUS_RESET});
        bus(1'b0, 4'h4, 32'h0);
        check("clear wo", rdat, 32'h0);
        bus(1'b1, 4'h8, 32'h3E);
        drive(5'h01);
        cyc(60);
        outs(5'h08);
        check("irq masked", irq, 32'h0);
        bus(1'b1, 4'h8, 32'h3F);
        cyc(1);
        check("irq on", irq, 32'h1);
        bus(1'b1, 4'h4, 32'h01);
        drive(5'h05);
        cyc(60);
        outs(5'h08);
        settle("ovchg", 32'h0);
        drive(5'h04);
        cyc(60);
        outs(5'h12);
        drive(5'h05);
        cyc(60);
        outs(5'h02);
        settle("ovcur first", 32'h05);
        drive(5'h02);
        cyc(60);
        outs(5'h15);
        drive(5'h06);
        cyc(60);
        outs(5'h15);
        settle("ovdis first", 32'h22);
        drive(5'h04);
        cyc(60);
        drive(5'h06);
        cyc(60);
        outs(5'h15);
        settle("ovcur then ovdis", 32'h26);
        drive(5'h01);
        cyc(60);
        drive(5'h03);
        cyc(60);
        outs(5'h04);
        settle("ovchg then ovdis", 32'h03);
        drive(5'h02);
        cyc(20);
        drive(5'h03);
        cyc(50);
        outs(5'h08);
        cyc(60);
        outs(5'h04);
        settle("interrupt", 32'h03);
        drive(5'h01);
        cyc(60);
        drive(5'h09);
        cyc(2520);
        outs(5'h00);
        settle("short", 32'h09);
        drive(5'h02);
        cyc(60);
        plug <= 1'b1;
        drive(5'h12);
        cyc(60);
        check("charge gate", cg, 32'h1);
        drive(5'h10);
        cyc(150);
        outs(5'h08);
        settle("charger", 32'h32);
        sh <= 1'b1;
        cyc(10);
        drive(5'h01);
        cyc(15);
        outs(5'h08);
        bus(1'b0, 4'hC, 32'h0);
        check("state", rdat, 32'h201);
        settle("shorten", 32'h01);
        close_out();
    end
    initial
    begin
        cyc(20000);
        bad_count++;
        close_out();
    end
endmodule // testbench
